// File: timer_one.sv
// 16-bit timer with clock-source, prescaler and crystal-pin control
// assumes a one-cycle read/write strobe port and pins synchronous to ref_clk
// Behaviour
// RQ1: divider field bits 5:4 divide count clock by 1, 2, 4 or 8.
// RQ2: bit 3 runs the crystal oscillator and overrides port C pin directions.
// RQ3: with oscillator on, pins 0 and 1 are amplifier output and input.
// RQ4: with external source, bit 2 picks synchronised (0) or direct (1) counting.
// RQ5: internal source ignores the sync bit and counts instruction cycles.
// RQ6: bit 1 picks external rising edges (1) or instruction clock (0).
// RQ7: bit 0 runs the counter; cleared, the counter holds.
// RQ8: control bits 7 and 6 read as zero.
// RQ9: six control bits are read/write and reset to zero.
// RQ10: oscillator keeps running while the processor sleeps.
// RQ11: attached crystal stays at or below 200 kHz, 32 kHz intended.
// RQ12: software waits for oscillator start-up; no start-up timer exists.
// RQ13: internal source advances once per instruction cycle, after the divider.
// RQ14: count wraps ffff to 0000 and sets the sticky overflow flag.
// RQ15: compare trigger clears count without flag; software write wins. Code ignores the trigger in direct external mode.
// RQ16: direct external mode counts even while the instruction clock halts.
`timescale 1ns/10ps
module timer_one import timer_one_pkg::*; #(
  parameter int INSTR_DIVIDE = INSTR_DIV
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic sleep,
  input wire logic special_event,
  input wire logic [1:0] port_c_direction,
  input wire logic [1:0] port_c_data,
  input wire logic [1:0] port_c_pin_in,
  output logic [1:0] port_c_pin_out,
  output logic [1:0] port_c_pin_oe_n,
  output logic osc_amp_enable,
  output logic overflow_irq,
  output logic [15:0] count_value
);
  localparam int DIV_W = $clog2(INSTR_DIVIDE);

  initial begin
    if (INSTR_DIVIDE < 2 || (INSTR_DIVIDE & (INSTR_DIVIDE - 1)) != 0)
      $error("instruction divide must be a power of two, at least 2");
  end

  logic [5:0] control_reg;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic flag_reg;
  logic irq_en_reg;
  logic [7:0] rdata_reg;
  logic [DIV_W-1:0] phase_reg;
  logic instr_tick_reg;
  logic [1:0] pin_out_reg;
  logic [1:0] pin_oe_n_reg;
  logic osc_reg;
  logic irq_reg;
  logic ext_src;
  logic ext_edge;
  logic sel_tick;
  logic count_tick;
  logic wr_lo;
  logic wr_hi;
  logic wrap;
  logic step;
  logic trig;
  mode_t mode;

  wire run = control_reg[RUN_BIT];
  wire src_ext = control_reg[SRC_BIT];
  wire no_sync = control_reg[SYNC_BIT];
  wire osc_en = control_reg[OSC_BIT];
  wire [1:0] div_code = control_reg[DIV_HI_BIT:DIV_LO_BIT];

  assign wr_lo = wr_en && addr == ADDR_COUNT_LO;
  assign wr_hi = wr_en && addr == ADDR_COUNT_HI;

  // control register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      control_reg <= CONTROL_RESET; // RQ9
    end else if (wr_en && addr == ADDR_CONTROL) begin
      control_reg <= wdata[5:0]; // RQ9
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_en_reg <= 1'b0;
    end else if (wr_en && addr == ADDR_IRQ_EN) begin
      irq_en_reg <= wdata[FLAG_BIT];
    end
  end

  // instruction clock is ref_clk / INSTR_DIVIDE and stops in sleep
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      phase_reg <= '0;
      instr_tick_reg <= 1'b0;
    end else if (sleep) begin
      instr_tick_reg <= 1'b0;
    end else begin
      phase_reg <= phase_reg + DIV_W'(1);
      instr_tick_reg <= phase_reg == DIV_W'(INSTR_DIVIDE - 1); // RQ13
    end
  end

  // with the oscillator on, the crystal input pin feeds the count path
  assign ext_src = osc_en ? port_c_pin_in[1] : port_c_pin_in[0]; // RQ3

  count_edge_detect u_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin(ext_src),
    .bypass(no_sync),
    .edge_out(ext_edge)
  );

  always_comb begin
    if (!run) begin
      mode = MODE_STOPPED; // RQ7
    end else if (!src_ext) begin
      mode = MODE_TIMER; // RQ5
    end else if (!no_sync) begin
      mode = MODE_SYNC_COUNT; // RQ4
    end else begin
      mode = MODE_ASYNC_COUNT; // RQ4
    end
  end

  // synchronised counting needs the instruction clock, so it stops in sleep
  always_comb begin
    case (mode)
      MODE_STOPPED: sel_tick = 1'b0;
      MODE_TIMER: sel_tick = instr_tick_reg; // RQ13
      MODE_SYNC_COUNT: sel_tick = ext_edge && !sleep; // RQ6
      MODE_ASYNC_COUNT: sel_tick = ext_edge; // RQ16
      default: sel_tick = 1'b0;
    endcase
  end

  input_divider #(.WIDTH(PRESC_WIDTH)) u_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick_in(sel_tick),
    .code(div_code),
    .clear(!run || wr_lo || wr_hi),
    .tick_out(count_tick)
  );

  assign trig = special_event && mode != MODE_ASYNC_COUNT; // RQ15
  // a tick still in the divider when run drops must not land after the stop
  assign step = count_tick && run; // RQ7
  // a trigger in the wrap cycle clears the count and takes the overflow with it
  assign wrap = step && count_reg == COUNT_MAX && !trig; // RQ14

  always_comb begin
    count_next = count_reg;
    if (wr_lo) begin
      count_next = {count_reg[15:8], wdata}; // RQ15
    end else if (wr_hi) begin
      count_next = {wdata, count_reg[7:0]}; // RQ15
    end else if (trig) begin
      count_next = COUNT_ZERO; // RQ15
    end else if (step) begin
      count_next = count_reg + 16'h0001; // RQ14
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_reg <= COUNT_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  // a wrap in the same cycle as a software clear still sets the flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_reg <= 1'b0;
    end else if (wrap && !wr_lo && !wr_hi) begin
      flag_reg <= 1'b1; // RQ14
    end else if (wr_en && addr == ADDR_FLAG) begin
      flag_reg <= wdata[FLAG_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg && irq_en_reg; // RQ14
    end
  end

  // oscillator runs regardless of sleep; only the control bit stops it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_reg <= 1'b0;
    end else begin
      osc_reg <= osc_en; // RQ2 RQ10
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_out_reg <= 2'h0;
      pin_oe_n_reg <= 2'h3;
    end else begin
      pin_out_reg <= port_c_data;
      pin_oe_n_reg <= port_c_direction | {2{osc_en}}; // RQ2 RQ3
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || !rd_en) begin
      rdata_reg <= 8'h00;
    end else begin
      case (addr)
        ADDR_CONTROL: rdata_reg <= {2'b00, control_reg}; // RQ8
        ADDR_COUNT_LO: rdata_reg <= count_reg[7:0];
        ADDR_COUNT_HI: rdata_reg <= count_reg[15:8];
        ADDR_FLAG: rdata_reg <= {7'h00, flag_reg};
        ADDR_IRQ_EN: rdata_reg <= {7'h00, irq_en_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign port_c_pin_out = pin_out_reg;
  assign port_c_pin_oe_n = pin_oe_n_reg;
  assign osc_amp_enable = osc_reg;
  assign overflow_irq = irq_reg;
  assign count_value = count_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  instr_rate_a: assert property (instr_tick_reg |=> !instr_tick_reg [*3])
    else $error("instruction tick too frequent"); // RQ13
  osc_pins_a: assert property (osc_en |=> port_c_pin_oe_n == 2'h3)
    else $error("pins driven while oscillator on"); // RQ3
  osc_follow_a: assert property (osc_en |=> osc_amp_enable)
    else $error("oscillator not enabled"); // RQ2
  osc_off_a: assert property (!osc_en |=> !osc_amp_enable)
    else $error("oscillator not shut off"); // RQ2
  osc_sleep_a: assert property ((sleep && osc_amp_enable && osc_en) |=> osc_amp_enable)
    else $error("oscillator stopped in sleep"); // RQ10
  internal_src_a: assert property ((run && !src_ext) |-> sel_tick == instr_tick_reg)
    else $error("internal source not instruction clock"); // RQ5
  ext_src_a: assert property ((run && src_ext && !sleep) |-> sel_tick == ext_edge)
    else $error("external edges not selected"); // RQ6
  stop_hold_a: assert property ((!run && !wr_lo && !wr_hi && !special_event) |=> $stable(count_value))
    else $error("count moved while stopped"); // RQ7
  unimpl_zero_a: assert property ((rd_en && addr == ADDR_CONTROL) |=> rdata[7:6] == 2'b00)
    else $error("unimplemented bits not zero"); // RQ8
  ctrl_reset_a: assert property ($past(rst) |-> control_reg == CONTROL_RESET)
    else $error("control not cleared by reset"); // RQ9
  wrap_flag_a: assert property ((wrap && !wr_lo && !wr_hi && !special_event) |=>
    count_value == COUNT_ZERO && flag_reg)
    else $error("wrap did not clear count and set flag"); // RQ14
  trigger_reset_a: assert property ((special_event && !wr_lo && !wr_hi && !flag_reg
    && mode != MODE_ASYNC_COUNT) |=> count_value == COUNT_ZERO && !flag_reg)
    else $error("trigger reset wrong"); // RQ15
  write_wins_a: assert property ((wr_lo && special_event) |=> count_value[7:0] == $past(wdata))
    else $error("trigger beat software write"); // RQ15
  pin_dir_a: assert property (!osc_en |=> port_c_pin_oe_n == $past(port_c_direction))
    else $error("port direction not followed"); // RQ2
  ctrl_read_a: assert property ((rd_en && addr == ADDR_CONTROL) |=> rdata[5:0] == $past(control_reg))
    else $error("control readback wrong"); // RQ9
  sleep_instr_a: assert property (sleep |=> !instr_tick_reg)
    else $error("instruction tick during sleep"); // RQ13
  sync_sleep_a: assert property ((sleep && run && src_ext && !no_sync) |-> !sel_tick)
    else $error("synchronised count moved in sleep"); // RQ4
  async_sleep_a: assert property ((sleep && mode == MODE_ASYNC_COUNT) |-> sel_tick == ext_edge)
    else $error("direct count stopped in sleep"); // RQ16
  irq_follow_a: assert property ((flag_reg && irq_en_reg) |=> overflow_irq)
    else $error("overflow request missing"); // RQ14
  flag_sticky_a: assert property ((flag_reg && !(wr_en && addr == ADDR_FLAG)) |=> flag_reg)
    else $error("overflow flag dropped by itself"); // RQ14

  wrap_seen_c: cover property (wrap ##2 overflow_irq);
  sync_count_c: cover property (mode == MODE_SYNC_COUNT && count_tick);
  trigger_seen_c: cover property (special_event && run && count_reg != COUNT_ZERO);
  async_sleep_c: cover property (sleep && mode == MODE_ASYNC_COUNT && count_tick);
endmodule

// File: timer_one_pkg.sv
// constants and types for the 16-bit timer and its clock-source control
// assumes a byte-wide register port and one 200 MHz clock
package timer_one_pkg;
  localparam logic [7:0] ADDR_FLAG = 8'h0c;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h0e;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h0f;
  localparam logic [7:0] ADDR_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h8c;
  localparam int RUN_BIT = 0;
  localparam int SRC_BIT = 1;
  localparam int SYNC_BIT = 2;
  localparam int OSC_BIT = 3;
  localparam int DIV_LO_BIT = 4;
  localparam int DIV_HI_BIT = 5;
  localparam int FLAG_BIT = 0;
  localparam logic [5:0] CONTROL_RESET = 6'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int INSTR_PERIOD_PS = 20000;
  localparam int INSTR_DIV = INSTR_PERIOD_PS / CLK_PERIOD_PS;
  localparam int PRESC_WIDTH = 3;
  typedef enum logic [1:0] {DIV1, DIV2, DIV4, DIV8} div_code_t;
  typedef enum logic [1:0] {MODE_STOPPED, MODE_TIMER, MODE_SYNC_COUNT, MODE_ASYNC_COUNT} mode_t;
endpackage

// File: input_divider.sv
// count-clock prescaler: passes one tick in 1, 2, 4 or 8
// assumes tick_in is a one-cycle pulse on ref_clk
`timescale 1ns/10ps
module input_divider import timer_one_pkg::*; #(
  parameter int WIDTH = PRESC_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick_in,
  input wire logic [1:0] code,
  input wire logic clear,
  output logic tick_out
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] mask;
  logic tick_out_reg;

  initial begin
    if (WIDTH < 3) $error("input_divider needs at least 3 bits");
  end

  always_comb begin
    case (div_code_t'(code))
      DIV1: mask = WIDTH'(0);
      DIV2: mask = WIDTH'(1);
      DIV4: mask = WIDTH'(3);
      DIV8: mask = WIDTH'(7);
      default: mask = WIDTH'(0);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      cnt_reg <= '0;
    end else if (tick_in) begin
      cnt_reg <= (cnt_reg & mask) == mask ? '0 : cnt_reg + WIDTH'(1); // RQ1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || clear) begin
      tick_out_reg <= 1'b0;
    end else begin
      tick_out_reg <= tick_in && ((cnt_reg & mask) == mask); // RQ1
    end
  end

  assign tick_out = tick_out_reg;

  // helper: input ticks since the last output tick
  logic [WIDTH:0] seen_reg;
  always_ff @(posedge ref_clk) begin
    if (rst || clear || tick_out_reg) begin
      seen_reg <= (tick_in && !(rst || clear)) ? (WIDTH+1)'(1) : '0;
    end else if (tick_in) begin
      seen_reg <= seen_reg + (WIDTH+1)'(1);
    end
  end

  div_ratio_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tick_out_reg && $stable(code) && !$past(clear)) |-> $past(seen_reg) == (WIDTH+1)'({1'b0, $past(mask)}))
    else $error("prescaler ratio wrong"); // RQ1
endmodule

// File: count_edge_detect.sv
// rising-edge finder for the external count input
// synchronised path or direct path, chosen by bypass
`timescale 1ns/10ps
module count_edge_detect (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic pin,
  input wire logic bypass,
  output logic edge_out
);
  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic raw_prev_reg;
  logic edge_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      raw_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      raw_prev_reg <= pin;
    end
  end

  // direct path saves two cycles of latency but trusts the pin timing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edge_reg <= 1'b0;
    end else if (bypass) begin
      edge_reg <= pin && !raw_prev_reg; // RQ16
    end else begin
      edge_reg <= sync2_reg && !sync3_reg; // RQ4
    end
  end

  assign edge_out = edge_reg;

  sync_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (edge_reg && $past(!bypass)) |-> $past(pin, 3) && !$past(pin, 4))
    else $error("synchronised edge timing wrong"); // RQ4
  raw_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (edge_reg && $past(bypass)) |-> $past(pin) && !$past(pin, 2))
    else $error("direct edge timing wrong"); // RQ16
endmodule

// File: ext_clock_source.sv
// far-side clock source: external count clock or watch crystal
// assumes a free-running ref_clk to time its half periods
`timescale 1ns/10ps
module ext_clock_source #(
  parameter int HALF = 8
) (
  input wire logic ref_clk,
  input wire logic run,
  output logic pin,
  output int rises
);
  int cnt;
  initial begin
    pin = 1'b0;
    rises = 0;
    cnt = 0;
  end
  // rate scaled up from the watch crystal to keep runs short
  // idle low outside bursts, never parked high
  always @(posedge ref_clk) begin
    if (!run) begin
      cnt <= 0;
      pin <= 1'b0;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= !pin;
      if (!pin) rises <= rises + 1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: timer_one_tb.sv
// self-checking bench for the timer and its clock-source control
// assumes the design answers reads one cycle after rd_en
`timescale 1ns/10ps
module timer_one_tb;
  import timer_one_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic sleep = 1'b0;
  logic special_event = 1'b0;
  logic [1:0] port_c_direction = 2'h1;
  logic [1:0] port_c_data = 2'h2;
  logic src_run = 1'b0;
  logic src_pin;
  logic [7:0] rdata;
  logic [1:0] pin_out;
  logic [1:0] oe_n;
  logic osc_on;
  logic irq;
  logic [15:0] count_value;
  int rises;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] r;

  always #2.5 ref_clk = ~ref_clk;

  timer_one uut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sleep(sleep),
    .special_event(special_event), .port_c_direction(port_c_direction),
    .port_c_data(port_c_data), .port_c_pin_in({src_pin, src_pin}),
    .port_c_pin_out(pin_out), .port_c_pin_oe_n(oe_n), .osc_amp_enable(osc_on),
    .overflow_irq(irq), .count_value(count_value));

  ext_clock_source src (.ref_clk(ref_clk), .run(src_run), .pin(src_pin),
    .rises(rises));

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // a hang counts as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic near(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
    comparisons++;
    if (!(g >= lo && g <= hi) || $isunknown(g)) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic set_count(input logic [15:0] v);
    wr(ADDR_COUNT_LO, v[7:0]);
    wr(ADDR_COUNT_HI, v[15:8]);
  endtask

  task automatic t_regs();
    rd(ADDR_CONTROL, r);
    chk(16'(r), 16'h0000);
    rd(8'h55, r);
    chk(16'(r), 16'h0000);
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, r);
    chk(16'(r), 16'h003f);
    chk(16'(osc_on), 16'h0001);
    chk(16'(oe_n), 16'h0003);
    @(posedge ref_clk) sleep <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(16'(osc_on), 16'h0001);
    sleep <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk(16'(osc_on), 16'h0000);
    chk(16'(oe_n), 16'h0001);
    chk(16'(pin_out), 16'h0002);
  endtask

  // odd codes also set the sync bit, which timer mode must ignore
  task automatic t_timer();
    logic [15:0] e;
    logic [15:0] held;
    for (int c = 0; c < 4; c++) begin
      set_count(16'h0000);
      wr(ADDR_CONTROL, 8'((c << 4) | ((c & 1) << 2) | 1));
      repeat (320) @(posedge ref_clk);
      wr(ADDR_CONTROL, 8'h00);
      repeat (2) @(posedge ref_clk);
      e = 16'(80 >> c);
      near(count_value, e - 16'h1, e + 16'h2);
      held = count_value;
      repeat (20) @(posedge ref_clk);
      chk(count_value, held);
    end
  endtask

  task automatic t_ext(input logic [7:0] ctl, input logic slp, input bit counts);
    int r0;
    set_count(16'h0000);
    @(posedge ref_clk) sleep <= slp;
    wr(ADDR_CONTROL, ctl);
    repeat (12) @(posedge ref_clk);
    r0 = rises;
    @(posedge ref_clk) src_run <= 1'b1;
    repeat (200) @(posedge ref_clk);
    src_run <= 1'b0;
    repeat (12) @(posedge ref_clk);
    wr(ADDR_CONTROL, 8'h00);
    sleep <= 1'b0;
    chk(count_value, counts ? 16'(rises - r0) : 16'h0000);
  endtask

  task automatic t_wrap();
    wr(ADDR_IRQ_EN, 8'h01);
    set_count(16'hfffc);
    wr(ADDR_CONTROL, 8'h01);
    repeat (40) @(posedge ref_clk);
    wr(ADDR_CONTROL, 8'h00);
    near(count_value, 16'h0004, 16'h0008);
    rd(ADDR_FLAG, r);
    chk(16'(r[0]), 16'h0001);
    chk(16'(irq), 16'h0001);
    wr(ADDR_FLAG, 8'h00);
    set_count(16'h1234);
    wr(ADDR_CONTROL, 8'h01);
    repeat (20) @(posedge ref_clk);
    special_event <= 1'b1;
    @(posedge ref_clk) special_event <= 1'b0;
    wr(ADDR_CONTROL, 8'h00);
    near(count_value, 16'h0000, 16'h0002);
    rd(ADDR_FLAG, r);
    chk(16'(r[0]), 16'h0000);
    // trigger in the same cycle as a low-byte write: the write must win
    fork
      wr(ADDR_COUNT_LO, 8'h5a);
      begin
        @(posedge ref_clk) special_event <= 1'b1;
        @(posedge ref_clk) special_event <= 1'b0;
      end
    join
    @(posedge ref_clk);
    chk(16'(count_value[7:0]), 16'h005a);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_timer();
    t_ext(8'h03, 1'b0, 1'b1);
    t_ext(8'h07, 1'b1, 1'b1);
    t_ext(8'h0b, 1'b0, 1'b1);
    t_ext(8'h03, 1'b1, 1'b0);
    t_ext(8'h01, 1'b1, 1'b0);
    t_wrap();
    tally_and_finish();
  end
endmodule
